// [rtl/cfgp_apb_slave.v]
`timescale 1ns/1ns
`default_nettype none
`include "cfgp_defines.vh"

module cfgp_apb_slave #(
    parameter ADDR_W = `CFGP_ADDR_W
) (
    // Clock and reset
    input wire ref_clk_in,
    input wire rst_in,
    // APB
    input wire psel_in,
    input wire penable_in,
    input wire pwrite_in,
    input wire [ADDR_W-1:0] paddr_in,
    input wire [31:0] pwdata_in,
    output wire pready_out,
    output wire pslverr_out,
    output wire [31:0] prdata_out,
    // Register file side
    output wire wr_stb_out,
    output wire [ADDR_W-1:0] addr_out,
    output wire [31:0] wdata_out,
    input wire [31:0] rdata_in,
    input wire hit_in
);
    reg [31:0] prdata_reg;
    reg [31:0] prdata_next;
    wire setup;
    wire access;

    assign setup = psel_in & ~penable_in;
    assign access = psel_in & penable_in;

    // Zero wait states: every access completes in its first access cycle
    assign pready_out = 1'b1;
    assign pslverr_out = access & ~hit_in;
    assign wr_stb_out = access & pwrite_in & hit_in;
    assign addr_out = paddr_in;
    assign wdata_out = pwdata_in;
    assign prdata_out = prdata_reg;

    // Read data captured in the setup cycle so it stands through the access phase
    always @* begin
        prdata_next = prdata_reg;
        if (setup & ~pwrite_in) begin
            prdata_next = hit_in ? rdata_in : 32'h0000_0000;
        end
    end

    always @(posedge ref_clk_in) begin
        if (rst_in) begin
            prdata_reg <= 32'h0000_0000;
        end else begin
            prdata_reg <= prdata_next;
        end
    end
endmodule // cfgp_apb_slave

`default_nettype wire

// [rtl/cfgp_config_change_protect.v]
`timescale 1ns/1ns
`default_nettype none
`include "cfgp_defines.vh"

module cfgp_config_change_protect #(
    parameter ADDR_W = `CFGP_ADDR_W,
    parameter IRQ_W = 2,
    parameter CNT_W = `CFGP_CNT_W
) (
    // Clock and reset
    input wire ref_clk_in,
    input wire rst_in,
    // APB slave
    input wire psel_in,
    input wire penable_in,
    input wire pwrite_in,
    input wire [ADDR_W-1:0] paddr_in,
    input wire [31:0] pwdata_in,
    output wire pready_out,
    output wire pslverr_out,
    output wire [31:0] prdata_out,
    // CPU execution events, one-cycle pulses
    input wire instr_done_in,
    input wire io_write_in,
    input wire mem_access_in,
    input wire sleep_in,
    // Protected write request and its gated strobe
    input wire prot_write_req_in,
    output wire prot_write_ok_out,
    // Memory controller command request and its gated strobe
    input wire nvm_cmd_req_in,
    output wire nvm_cmd_ok_out,
    // Interrupt gating
    input wire [IRQ_W-1:0] irq_pending_in,
    output wire [IRQ_W-1:0] irq_take_out,
    output wire irq_hold_out,
    // Window state
    output wire io_unlocked_out,
    output wire spm_unlocked_out
);
    localparam NW = `CFGP_NUM_WIN;
    localparam WIO = `CFGP_WIN_IO;
    localparam WSP = `CFGP_WIN_SPM;

    // Bus side
    wire wr_stb;
    wire [ADDR_W-1:0] bus_addr;
    wire [31:0] bus_wdata;
    reg [31:0] bus_rdata;
    reg bus_hit;

    // Decoded writes
    wire key_wr;
    wire refused_wr;
    wire [7:0] key_val;
    wire io_key_hit;
    wire spm_key_hit;

    // Window control
    wire [NW-1:0] win_open;
    wire [NW-1:0] win_kill;
    wire [NW-1:0] win_active;
    wire [NW*CNT_W-1:0] win_count;
    wire any_open;
    wire [CNT_W-1:0] remain;

    // Refused attempt flags, software clears by writing one
    reg [1:0] refused_reg;
    reg [1:0] refused_next;
    wire io_refused;
    wire spm_refused;

    // Key register readback
    wire [7:0] key_read;

    cfgp_apb_slave #(
        .ADDR_W(ADDR_W)
    ) u_apb (
        .ref_clk_in(ref_clk_in),
        .rst_in(rst_in),
        .psel_in(psel_in),
        .penable_in(penable_in),
        .pwrite_in(pwrite_in),
        .paddr_in(paddr_in),
        .pwdata_in(pwdata_in),
        .pready_out(pready_out),
        .pslverr_out(pslverr_out),
        .prdata_out(prdata_out),
        .wr_stb_out(wr_stb),
        .addr_out(bus_addr),
        .wdata_out(bus_wdata),
        .rdata_in(bus_rdata),
        .hit_in(bus_hit)
    );

    assign key_wr = wr_stb & (bus_addr == `CFGP_OFS_KEY);
    assign refused_wr = wr_stb & (bus_addr == `CFGP_OFS_REFUSED);
    assign key_val = bus_wdata[7:0];

    // Only the two exact key values open anything; any other value is dropped
    assign io_key_hit = key_wr & (key_val == `CFGP_IO_UNLOCK_KEY);
    assign spm_key_hit = key_wr & (key_val == `CFGP_SELF_PROGRAM_KEY);

    // A new key of one kind ends the other kind's window
    assign win_open[WIO] = io_key_hit;
    assign win_open[WSP] = spm_key_hit;

    // The key write itself arrives on the bus, so io_write_in never carries it
    assign win_kill[WIO] = io_write_in | mem_access_in | sleep_in | spm_key_hit;
    assign win_kill[WSP] = mem_access_in | sleep_in | io_key_hit;

    // One countdown per window, opened by its key and stepped per instruction
    genvar gi;
    generate
        for (gi = 0; gi < NW; gi = gi + 1) begin : g_win
            cfgp_window_timer #(
                .CNT_W(CNT_W),
                .LENGTH(`CFGP_WINDOW_INSTR)
            ) u_timer (
                .ref_clk_in(ref_clk_in),
                .rst_in(rst_in),
                .open_in(win_open[gi]),
                .kill_in(win_kill[gi]),
                .step_in(instr_done_in),
                .active_out(win_active[gi]),
                .count_out(win_count[gi*CNT_W +: CNT_W])
            );
        end
    endgenerate

    assign io_unlocked_out = win_active[WIO];
    assign spm_unlocked_out = win_active[WSP];
    assign any_open = |win_active;

    // Remaining instructions of whichever window is open
    assign remain = win_active[WIO] ? win_count[WIO*CNT_W +: CNT_W]
                                    : win_count[WSP*CNT_W +: CNT_W];

    // Gated strobes; the closing access itself still completes in its cycle
    assign prot_write_ok_out = prot_write_req_in & win_active[WIO];
    assign nvm_cmd_ok_out = nvm_cmd_req_in & win_active[WSP];
    assign io_refused = prot_write_req_in & ~win_active[WIO];
    assign spm_refused = nvm_cmd_req_in & ~win_active[WSP];

    // Requests keep their flags in the interrupt controller; only service waits
    assign irq_hold_out = any_open;
    assign irq_take_out = irq_pending_in & {IRQ_W{~any_open}};

    // Status bits only: the key value itself is never stored or read back
    assign key_read = {6'b00_0000, win_active[WSP], win_active[WIO]};

    // Refused flags: a new refusal in the clearing cycle survives the clear
    always @* begin
        refused_next = refused_reg;
        if (refused_wr) begin
            refused_next = refused_reg & ~bus_wdata[1:0];
        end
        if (io_refused) begin
            refused_next[0] = 1'b1;
        end
        if (spm_refused) begin
            refused_next[1] = 1'b1;
        end
    end

    always @(posedge ref_clk_in) begin
        if (rst_in) begin
            refused_reg <= 2'b00;
        end else begin
            refused_reg <= refused_next;
        end
    end

    // Read decode; unmapped addresses answer with an error
    always @* begin
        bus_rdata = 32'h0000_0000;
        bus_hit = 1'b1;
        case (bus_addr)
            `CFGP_OFS_KEY: begin
                bus_rdata = {24'h00_0000, key_read};
            end
            `CFGP_OFS_STATUS: begin
                bus_rdata[WIO] = win_active[WIO];
                bus_rdata[WSP] = win_active[WSP];
                bus_rdata[`CFGP_STAT_CNT_MSB:`CFGP_STAT_CNT_LSB] = remain;
            end
            `CFGP_OFS_REFUSED: begin
                bus_rdata[1:0] = refused_reg;
            end
            default: begin
                bus_hit = 1'b0;
            end
        endcase
    end
endmodule // cfgp_config_change_protect

`default_nettype wire

// [rtl/cfgp_defines.vh]
`ifndef CFGP_DEFINES_VH
`define CFGP_DEFINES_VH

// APB byte addresses
`define CFGP_ADDR_W 8
`define CFGP_OFS_KEY 8'h04
`define CFGP_OFS_STATUS 8'h08
`define CFGP_OFS_REFUSED 8'h0C

// Key values
`define CFGP_IO_UNLOCK_KEY 8'hD8
`define CFGP_SELF_PROGRAM_KEY 8'h9D
`define CFGP_KEY_RESET 8'h00

// Window identifiers and field positions
`define CFGP_WIN_IO 0
`define CFGP_WIN_SPM 1
`define CFGP_NUM_WIN 2
`define CFGP_STAT_CNT_LSB 2
`define CFGP_STAT_CNT_MSB 4

// Window length in executed instructions
`define CFGP_WINDOW_INSTR 3'h4
`define CFGP_CNT_W 3

`endif

// [rtl/cfgp_window_timer.v]
`timescale 1ns/1ns
`default_nettype none
`include "cfgp_defines.vh"

module cfgp_window_timer #(
    parameter CNT_W = `CFGP_CNT_W,
    parameter [CNT_W-1:0] LENGTH = `CFGP_WINDOW_INSTR
) (
    // Clock and reset
    input wire ref_clk_in,
    input wire rst_in,
    // Control
    input wire open_in,
    input wire kill_in,
    input wire step_in,
    // State
    output wire active_out,
    output wire [CNT_W-1:0] count_out
);
    reg [CNT_W-1:0] count_reg;
    reg [CNT_W-1:0] count_next;

    assign active_out = (count_reg != {CNT_W{1'b0}});
    assign count_out = count_reg;

    // A fresh key restarts the window even if a closing access lands alongside
    always @* begin
        count_next = count_reg;
        if (open_in) begin
            count_next = LENGTH;
        end else if (kill_in) begin
            count_next = {CNT_W{1'b0}};
        end else if (step_in && active_out) begin
            count_next = count_reg - {{(CNT_W-1){1'b0}}, 1'b1};
        end
    end

    always @(posedge ref_clk_in) begin
        if (rst_in) begin
            count_reg <= {CNT_W{1'b0}};
        end else begin
            count_reg <= count_next;
        end
    end
endmodule // cfgp_window_timer

`default_nettype wire

// [verification/cfgp_checker_sva.sv]
`timescale 1ns/1ns
`default_nettype none
module cfgp_checker #(
    parameter ADDR_W = 8,
    parameter IRQ_W = 2
) (
    // Watched design ports
    input wire ref_clk_in,
    input wire rst_in,
    input wire psel_in,
    input wire penable_in,
    input wire pwrite_in,
    input wire [ADDR_W-1:0] paddr_in,
    input wire [31:0] pwdata_in,
    input wire instr_done_in,
    input wire io_write_in,
    input wire mem_access_in,
    input wire sleep_in,
    input wire prot_write_req_in,
    input wire prot_write_ok_out,
    input wire [IRQ_W-1:0] irq_pending_in,
    input wire [IRQ_W-1:0] irq_take_out,
    input wire irq_hold_out,
    input wire io_unlocked_out,
    input wire spm_unlocked_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);
    wire kw = psel_in && penable_in && pwrite_in && paddr_in == 8'h04;
    wire any_open = io_unlocked_out || spm_unlocked_out;
    logic [2:0] n_reg;
    // Any key write restarts the count, so a stray write can only hide a fault
    always @(posedge ref_clk_in) begin
        if (rst_in || kw) begin
            n_reg <= 3'h0;
        end else if (any_open && instr_done_in) begin
            n_reg <= n_reg + 3'h1;
        end
    end
    io_key_a: assert property (kw && pwdata_in[7:0] == 8'hd8 |=> io_unlocked_out)
        else $error("io key did not open");
    spm_key_a: assert property (kw && pwdata_in[7:0] == 8'h9d |=> spm_unlocked_out)
        else $error("program key did not open");
    four_instr_a: assert property (any_open |-> n_reg < 3'h4)
        else $error("window outlived four instructions");
    prot_gate_a: assert property (prot_write_ok_out == (prot_write_req_in && io_unlocked_out))
        else $error("protected write gate wrong");
    irq_hold_a: assert property (any_open |-> irq_hold_out && irq_take_out == '0)
        else $error("interrupt taken in window");
    irq_free_a: assert property (!any_open |-> irq_take_out == irq_pending_in)
        else $error("pending interrupt not released");
    io_close_a: assert property (io_unlocked_out && !kw &&
        (io_write_in || mem_access_in || sleep_in) |=> !io_unlocked_out)
        else $error("io window not closed");
    spm_close_a: assert property (spm_unlocked_out && !kw &&
        (mem_access_in || sleep_in) |=> !spm_unlocked_out)
        else $error("program window not closed");
    cover property (kw && pwdata_in[7:0] == 8'hd8);
    cover property (kw && pwdata_in[7:0] == 8'h9d);
    cover property (any_open && irq_pending_in != '0);
endmodule // cfgp_checker
`default_nettype wire

// [verification/cfgp_config_change_protect_bench.sv]
`timescale 1ns/1ns
`default_nettype none
module cfgp_config_change_protect_bench;
    logic ref_clk_in = 1'h0;
    logic rst_in = 1'h1;
    logic psel = 1'h0;
    logic pen = 1'h0;
    logic pwr = 1'h0;
    logic [7:0] pad = 8'h00;
    logic [31:0] pwd = 32'h0000_0000;
    // Instr, io write, memory, sleep, protected write, command
    logic [5:0] ev = 6'h00;
    logic [1:0] raise = 2'h0;
    logic [1:0] okv;
    logic [31:0] rd;
    logic err;
    wire pready;
    wire perr;
    wire [31:0] prdata;
    wire prot_ok;
    wire nvm_ok;
    wire hold;
    wire [1:0] pend;
    wire [1:0] take;
    wire io_unl;
    wire spm_unl;
    int n_errors = 0;
    int tests_run = 0;
    int cyc = 0;
    cfgp_config_change_protect u_cfgp_config_change_protect (
        .ref_clk_in(ref_clk_in), .rst_in(rst_in), .psel_in(psel),
        .penable_in(pen), .pwrite_in(pwr), .paddr_in(pad), .pwdata_in(pwd),
        .pready_out(pready), .pslverr_out(perr), .prdata_out(prdata),
        .instr_done_in(ev[5]), .io_write_in(ev[4]), .mem_access_in(ev[3]),
        .sleep_in(ev[2]), .prot_write_req_in(ev[1]), .prot_write_ok_out(prot_ok),
        .nvm_cmd_req_in(ev[0]), .nvm_cmd_ok_out(nvm_ok), .irq_pending_in(pend),
        .irq_take_out(take), .irq_hold_out(hold), .io_unlocked_out(io_unl),
        .spm_unlocked_out(spm_unl));
    cfgp_irq_source u_cfgp_irq_source (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
        .raise_in(raise), .take_in(take), .pending_out(pend));
    initial begin
        forever #50 ref_clk_in = ~ref_clk_in;
    end
    always @(posedge ref_clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            n_errors++;
            end_sim();
        end
    end
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %0t seen %h want %h", $time, seen, exp);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk_in);
        psel <= 1'h1;
        pwr <= w;
        pad <= a;
        pwd <= d;
        @(posedge ref_clk_in);
        pen <= 1'h1;
        do @(posedge ref_clk_in); while (pready !== 1'h1);
        rd = prdata;
        err = perr;
        psel <= 1'h0;
        pen <= 1'h0;
    endtask
    task pulse(input logic [5:0] e);
        @(posedge ref_clk_in);
        ev <= e;
        @(negedge ref_clk_in);
        okv = {prot_ok, nvm_ok};
        @(posedge ref_clk_in);
        ev <= 6'h00;
    endtask
    task t_reset;
        apb(1'h0, 8'h04, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        apb(1'h0, 8'h40, 32'h0000_0000);
        chk(err, 1'h1);
    endtask
    task t_io;
        apb(1'h1, 8'h04, 32'h0000_00d8);
        @(negedge ref_clk_in);
        chk({io_unl, spm_unl}, 2'h2);
        apb(1'h0, 8'h04, 32'h0000_0000);
        chk(rd, 32'h0000_0001);
        apb(1'h0, 8'h08, 32'h0000_0000);
        chk(rd, 32'h0000_0011);
        repeat (4) begin
            pulse(6'h22);
            chk(okv, 2'h2);
        end
        pulse(6'h02);
        chk(okv, 2'h0);
        @(negedge ref_clk_in);
        chk({io_unl, spm_unl}, 2'h0);
    endtask
    task t_spm;
        apb(1'h1, 8'h04, 32'h0000_009d);
        @(negedge ref_clk_in);
        chk({io_unl, spm_unl}, 2'h1);
        apb(1'h0, 8'h04, 32'h0000_0000);
        chk(rd, 32'h0000_0002);
        pulse(6'h23);
        chk(okv, 2'h1);
    endtask
    task t_close;
        logic [29:0] cl;
        cl = {6'h04, 6'h08, 6'h04, 6'h08, 6'h10};
        for (int i = 0; i < 5; i++) begin
            apb(1'h1, 8'h04, i < 3 ? 32'h0000_00d8 : 32'h0000_009d);
            pulse(cl[6*i +: 6]);
            pulse(6'h03);
            chk(okv, 2'h0);
        end
    endtask
    task t_bad;
        apb(1'h1, 8'h04, 32'h0000_00d9);
        apb(1'h0, 8'h04, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        // Earlier refused requests of both kinds must have left their flags set
        apb(1'h0, 8'h0c, 32'h0000_0000);
        chk(rd, 32'h0000_0003);
        apb(1'h1, 8'h0c, 32'h0000_0003);
        apb(1'h0, 8'h0c, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
    endtask
    task t_irq;
        apb(1'h1, 8'h04, 32'h0000_00d8);
        @(posedge ref_clk_in);
        raise <= 2'h3;
        @(posedge ref_clk_in);
        raise <= 2'h0;
        @(negedge ref_clk_in);
        chk({hold, pend, take}, 5'h1c);
        repeat (4) pulse(6'h20);
        @(negedge ref_clk_in);
        chk({hold, pend, take}, 5'h0f);
        @(negedge ref_clk_in);
        chk(pend, 2'h0);
    endtask
    task end_sim;
        if (n_errors == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge ref_clk_in);
        rst_in <= 1'h0;
        t_reset();
        t_io();
        t_spm();
        t_close();
        t_bad();
        t_irq();
        end_sim();
    end
endmodule // cfgp_config_change_protect_bench
bind cfgp_config_change_protect cfgp_checker #(.ADDR_W(ADDR_W), .IRQ_W(IRQ_W)) u_cfgp_checker (
    .ref_clk_in(ref_clk_in), .rst_in(rst_in), .psel_in(psel_in), .penable_in(penable_in),
    .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
    .instr_done_in(instr_done_in), .io_write_in(io_write_in), .mem_access_in(mem_access_in),
    .sleep_in(sleep_in), .prot_write_req_in(prot_write_req_in),
    .prot_write_ok_out(prot_write_ok_out), .irq_pending_in(irq_pending_in),
    .irq_take_out(irq_take_out), .irq_hold_out(irq_hold_out),
    .io_unlocked_out(io_unlocked_out), .spm_unlocked_out(spm_unlocked_out));
`default_nettype wire

// [verification/cfgp_irq_source.sv]
`timescale 1ns/1ns
`default_nettype none
module cfgp_irq_source (
    // Clock, requests and service
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic [1:0] raise_in,
    input wire logic [1:0] take_in,
    output logic [1:0] pending_out
);
    // A flag stays set until serviced, so a request made in a window is not lost
    always @(posedge ref_clk_in) begin
        pending_out <= rst_in ? 2'h0 : (pending_out & ~take_in) | raise_in;
    end
endmodule // cfgp_irq_source
`default_nettype wire
